// File: hdl/dfs_defrost_sequencer.v
`include "dfs_regs.vh"
// Operation
// - defrost only under cooling control type
// - mode auto/hand or binary input enables
// - display alternates value 2s, message 1s
// - auto mode requests on interval expiry
// - start needs pv<=sp, cooling off, pv<end
// - pending request held, starts when conditions hold
// - temperature end: end temp or max time
// - time end: max time only
// - sensor fault: end after fault time
// - abort on manual, self-tune, mode off
// - binary input request is edge triggered
// - input defrost ends on normal conditions
// - auto mode resumes cycling after input defrost
// - hand mode runs once, then mode off
// - aux output follows defrost when assigned
// - manual drives output, pulsating indicator
// - manual signal 0/100% on-off, any PID
module dfs_defrost_sequencer #(
   parameter TICK_CYCLES = `DFS_TICK_CYCLES // cycles per second tick
) (
   input wire clock, // 40 MHz system clock
   input wire rstn, // async reset, active low
   input wire [11:0] s_axi_awaddr, // write address
   input wire s_axi_awvalid, // write address valid
   output wire s_axi_awready, // write address ready
   input wire [31:0] s_axi_wdata, // write data
   input wire [3:0] s_axi_wstrb, // write byte strobes
   input wire s_axi_wvalid, // write data valid
   output wire s_axi_wready, // write data ready
   output reg [1:0] s_axi_bresp, // write response
   output reg s_axi_bvalid, // write response valid
   input wire s_axi_bready, // write response ready
   input wire [11:0] s_axi_araddr, // read address
   input wire s_axi_arvalid, // read address valid
   output wire s_axi_arready, // read address ready
   output reg [31:0] s_axi_rdata, // read data
   output reg [1:0] s_axi_rresp, // read response
   output reg s_axi_rvalid, // read data valid
   input wire s_axi_rready, // read data ready
   input wire [15:0] process_value, // measured temperature, signed
   input wire sensor_fault, // sensor defective flag, same clock
   input wire control_demand, // cooling demand of the control loop
   input wire binary_input, // binary input contacts shorted, pin
   output reg cooling_output, // cooling relay drive
   output reg aux_output, // auxiliary relay drive
   output reg defrost_active, // defrost running
   output reg show_message, // display shows defrost message
   output reg manual_led // pulsating manual indicator
);
   // ----------------------------------------
   // registers
   // ----------------------------------------
   reg [31:0] ctrl;
   reg [15:0] setpoint;
   reg [15:0] defrost_end_temperature;
   reg [15:0] defrost_interval;
   reg [15:0] defrost_max_time;
   reg [15:0] defrost_fault_time;
   reg [9:0] manual_signal;
   reg pending, from_input, hand_done;
   reg [15:0] interval_count, run_count;
   reg [1:0] disp_count;
   reg aw_held, w_held;
   reg [11:0] aw_addr;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   wire tick;
   wire bin_sync;
   reg bin_last;

   wire [1:0] mode = ctrl[`DFS_CTRL_MODE_LSB +: 2];
   wire cooling_type = ctrl[`DFS_CTRL_COOLING_BIT];
   wire end_by_time = ctrl[`DFS_CTRL_END_TIME_BIT];
   wire bin_defrost = ctrl[`DFS_CTRL_BIN_DEFROST_BIT];
   wire aux_defrost = ctrl[`DFS_CTRL_AUX_DEFROST_BIT];
   wire pid_type = ctrl[`DFS_CTRL_PID_BIT];
   wire manual = ctrl[`DFS_CTRL_MANUAL_BIT];
   wire self_tune = ctrl[`DFS_CTRL_TUNE_BIT];

   dfs_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
      .clock(clock),
      .rstn(rstn),
      .tick(tick)
   );
   dfs_sync u_sync (
      .clock(clock),
      .rstn(rstn),
      .din(binary_input),
      .dout(bin_sync)
   );

   // ----------------------------------------
   // axi4-lite slave
   // ----------------------------------------
   // one write and one read at a time; address and data taken in either order
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   wire aw_now = aw_held || (s_axi_awvalid && s_axi_awready);
   wire w_now = w_held || (s_axi_wvalid && s_axi_wready);
   wire [11:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
   wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
   wire [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb;
   wire do_write = aw_now && w_now && !s_axi_bvalid;
   wire [31:0] wmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};

   function [31:0] merge;
      input [31:0] old;
      input [31:0] dat;
      input [31:0] m;
      begin
         merge = (old & ~m) | (dat & m);
      end
   endfunction

   function [15:0] merge16;
      input [15:0] old;
      input [15:0] dat;
      input [15:0] m;
      begin
         merge16 = (old & ~m) | (dat & m);
      end
   endfunction

   wire wr_known = (wr_addr == `DFS_CTRL_ADDR) || (wr_addr == `DFS_SETPOINT_ADDR) ||
      (wr_addr == `DFS_END_TEMP_ADDR) || (wr_addr == `DFS_INTERVAL_ADDR) ||
      (wr_addr == `DFS_MAX_TIME_ADDR) || (wr_addr == `DFS_FAULT_TIME_ADDR) ||
      (wr_addr == `DFS_MANUAL_ADDR);
   wire [31:0] ctrl_written = merge(ctrl, wr_data, wmask);
   wire ctrl_wr = do_write && (wr_addr == `DFS_CTRL_ADDR);

   // manual signal clamp: on-off allows only the two extremes
   wire [31:0] man_in = merge({22'h000000, manual_signal}, wr_data, wmask);
   wire [9:0] man_lim = (man_in[9:0] > 10'h3E8) ? 10'h3E8 : man_in[9:0];
   wire [9:0] man_set = pid_type ? man_lim : ((man_lim >= 10'h1F4) ? 10'h3E8 : 10'h000);

   // ----------------------------------------
   // sequencing conditions
   // ----------------------------------------
   wire signed [15:0] pv = process_value;
   wire start_ok = ($signed(pv) <= $signed(setpoint)) && !cooling_output &&
      ($signed(pv) < $signed(defrost_end_temperature));
   wire bin_edge = bin_sync && !bin_last && bin_defrost;
   wire interval_hit = tick && (mode == `DFS_MODE_AUTO) &&
      (interval_count + 16'h0001 >= defrost_interval);
   wire hand_req = (mode == `DFS_MODE_HAND) && !hand_done;
   wire aborting = manual || self_tune || (mode == `DFS_MODE_OFF && !from_input);
   wire time_up = sensor_fault ? (run_count >= defrost_fault_time)
      : (run_count >= defrost_max_time);
   wire temp_end = !sensor_fault && !end_by_time &&
      ($signed(pv) >= $signed(defrost_end_temperature));
   wire finish = defrost_active && (time_up || temp_end);
   wire abort_now = defrost_active && (aborting || !cooling_type);
   // cooling must already be low on the edge at which a defrost starts
   wire start_now = cooling_type && !defrost_active && !manual && !self_tune && start_ok &&
      (pending || bin_edge || interval_hit || hand_req);

   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 12'h000;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `DFS_AXI_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= `DFS_AXI_OKAY;
         s_axi_rdata <= 32'h00000000;
         ctrl <= `DFS_CTRL_RESET;
         setpoint <= 16'h0000;
         defrost_end_temperature <= 16'h0000;
         defrost_interval <= `DFS_INTERVAL_RESET;
         defrost_max_time <= `DFS_MAX_TIME_RESET;
         defrost_fault_time <= `DFS_FAULT_TIME_RESET;
         manual_signal <= 10'h000;
      end else begin
         if (s_axi_awvalid && s_axi_awready && !do_write) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready && !do_write) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known ? `DFS_AXI_OKAY : `DFS_AXI_SLVERR;
            case (wr_addr)
               `DFS_SETPOINT_ADDR: setpoint <= merge16(setpoint, wr_data[15:0], wmask[15:0]);
               `DFS_END_TEMP_ADDR: defrost_end_temperature <=
                  merge16(defrost_end_temperature, wr_data[15:0], wmask[15:0]);
               `DFS_INTERVAL_ADDR: defrost_interval <=
                  merge16(defrost_interval, wr_data[15:0], wmask[15:0]);
               `DFS_MAX_TIME_ADDR: defrost_max_time <=
                  merge16(defrost_max_time, wr_data[15:0], wmask[15:0]);
               `DFS_FAULT_TIME_ADDR: defrost_fault_time <=
                  merge16(defrost_fault_time, wr_data[15:0], wmask[15:0]);
               `DFS_MANUAL_ADDR: manual_signal <= man_set;
               default: ;
            endcase
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         // hand mode completion rewrites the mode to off, software write wins
         if (ctrl_wr) begin
            ctrl <= {23'h000000, ctrl_written[8:0]};
         end else if (finish && (mode == `DFS_MODE_HAND) && !from_input) begin
            ctrl[`DFS_CTRL_MODE_LSB +: 2] <= `DFS_MODE_OFF;
         end
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `DFS_AXI_OKAY;
            case (s_axi_araddr)
               `DFS_CTRL_ADDR: s_axi_rdata <= ctrl;
               `DFS_SETPOINT_ADDR: s_axi_rdata <= {16'h0000, setpoint};
               `DFS_END_TEMP_ADDR: s_axi_rdata <= {16'h0000, defrost_end_temperature};
               `DFS_INTERVAL_ADDR: s_axi_rdata <= {16'h0000, defrost_interval};
               `DFS_MAX_TIME_ADDR: s_axi_rdata <= {16'h0000, defrost_max_time};
               `DFS_FAULT_TIME_ADDR: s_axi_rdata <= {16'h0000, defrost_fault_time};
               `DFS_MANUAL_ADDR: s_axi_rdata <= {22'h000000, manual_signal};
               `DFS_STATUS_ADDR: s_axi_rdata <= {16'h0000, run_count[11:0], pending,
                  from_input, show_message, defrost_active};
               `DFS_PV_ADDR: s_axi_rdata <= {16'h0000, process_value};
               default: begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= `DFS_AXI_SLVERR;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // defrost sequencing
   // ----------------------------------------
   // pending is volatile on purpose: power loss (reset) or a control type other than cooling forgets it
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         bin_last <= 1'b0;
         pending <= 1'b0;
         from_input <= 1'b0;
         hand_done <= 1'b0;
         defrost_active <= 1'b0;
         interval_count <= 16'h0000;
         run_count <= 16'h0000;
      end else begin
         bin_last <= bin_sync;
         if (mode != `DFS_MODE_HAND) begin
            hand_done <= 1'b0;
         end
         if (!cooling_type) begin
            pending <= 1'b0;
            defrost_active <= 1'b0;
            from_input <= 1'b0;
         end else if (defrost_active) begin
            if (abort_now || finish) begin
               defrost_active <= 1'b0;
               from_input <= 1'b0;
               interval_count <= 16'h0000;
               if (finish && mode == `DFS_MODE_HAND && !from_input) begin
                  hand_done <= 1'b1;
               end
            end else if (tick) begin
               run_count <= run_count + 16'h0001;
            end
            if (bin_edge || interval_hit) begin
               pending <= 1'b1;
            end
         end else begin
            if (tick && mode == `DFS_MODE_AUTO) begin
               interval_count <= interval_hit ? 16'h0000 : interval_count + 16'h0001;
            end
            if ((pending || bin_edge || interval_hit || hand_req) && !manual && !self_tune) begin
               if (start_ok) begin
                  defrost_active <= 1'b1;
                  pending <= 1'b0;
                  run_count <= 16'h0000;
                  from_input <= bin_edge || (from_input && pending);
                  if (hand_req) begin
                     hand_done <= 1'b1;
                  end
               end else begin
                  pending <= 1'b1;
                  if (bin_edge) begin
                     from_input <= 1'b1;
                  end
               end
            end
         end
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   // three-second display cycle: two of value, one of message
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         disp_count <= 2'h0;
         show_message <= 1'b0;
         cooling_output <= 1'b0;
         aux_output <= 1'b0;
         manual_led <= 1'b0;
      end else begin
         if (!defrost_active) begin
            disp_count <= 2'h0;
            show_message <= 1'b0;
         end else if (tick) begin
            disp_count <= (disp_count == 2'h2) ? 2'h0 : disp_count + 2'h1;
            show_message <= (disp_count == 2'h1);
         end
         if (manual) begin
            cooling_output <= (manual_signal >= 10'h1F4);
         end else begin
            cooling_output <= control_demand && !defrost_active && !start_now;
         end
         aux_output <= aux_defrost && defrost_active;
         if (!manual) begin
            manual_led <= 1'b0;
         end else if (tick) begin
            manual_led <= !manual_led;
         end
      end
   end
endmodule // dfs_defrost_sequencer

// File: hdl/dfs_regs.vh
`ifndef DFS_REGS_VH
`define DFS_REGS_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define DFS_CTRL_ADDR 12'h000
`define DFS_SETPOINT_ADDR 12'h004
`define DFS_END_TEMP_ADDR 12'h008
`define DFS_INTERVAL_ADDR 12'h00C
`define DFS_MAX_TIME_ADDR 12'h010
`define DFS_FAULT_TIME_ADDR 12'h014
`define DFS_MANUAL_ADDR 12'h018
`define DFS_STATUS_ADDR 12'h01C
`define DFS_PV_ADDR 12'h020
// ----------------------------------------
// control register fields
// ----------------------------------------
`define DFS_CTRL_MODE_LSB 0
`define DFS_CTRL_COOLING_BIT 2
`define DFS_CTRL_END_TIME_BIT 3
`define DFS_CTRL_BIN_DEFROST_BIT 4
`define DFS_CTRL_AUX_DEFROST_BIT 5
`define DFS_CTRL_PID_BIT 6
`define DFS_CTRL_MANUAL_BIT 7
`define DFS_CTRL_TUNE_BIT 8
`define DFS_CTRL_RESET 32'h00000000
// ----------------------------------------
// mode encodings
// ----------------------------------------
`define DFS_MODE_OFF 2'h0
`define DFS_MODE_AUTO 2'h1
`define DFS_MODE_HAND 2'h2
// ----------------------------------------
// reset values of timing registers, in seconds
// ----------------------------------------
`define DFS_INTERVAL_RESET 16'h0E10
`define DFS_MAX_TIME_RESET 16'h0708
`define DFS_FAULT_TIME_RESET 16'h0384
// ----------------------------------------
// timing
// ----------------------------------------
`define DFS_CLOCK_HZ 40000000
`define DFS_TICK_SECONDS 1
`define DFS_TICK_CYCLES (`DFS_CLOCK_HZ * `DFS_TICK_SECONDS)
`define DFS_SHOW_PV_SECONDS 2
`define DFS_SHOW_MSG_SECONDS 1
`define DFS_MANUAL_BLINK_SECONDS 1
`define DFS_AXI_OKAY 2'h0
`define DFS_AXI_SLVERR 2'h2
`endif

// File: hdl/dfs_tick.v
`include "dfs_regs.vh"
module dfs_tick #(
   parameter TICK_CYCLES = `DFS_TICK_CYCLES
) (
   input wire clock, // system clock
   input wire rstn, // async reset, active low
   output reg tick // one-cycle pulse each second
);
   reg [31:0] count;
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         count <= 32'h00000000;
         tick <= 1'b0;
      end else if (count >= TICK_CYCLES - 1) begin
         count <= 32'h00000000;
         tick <= 1'b1;
      end else begin
         count <= count + 32'h00000001;
         tick <= 1'b0;
      end
   end
endmodule // dfs_tick

// File: hdl/dfs_sync.v
module dfs_sync (
   input wire clock, // system clock
   input wire rstn, // async reset, active low
   input wire din, // asynchronous level
   output reg dout // synchronised level
);
   reg meta;
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         meta <= 1'b0;
         dout <= 1'b0;
      end else begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule // dfs_sync

// File: dv/dfs_defrost_sequencer_assertions.sv
module dfs_defrost_sequencer_chk #(
   parameter TICK_CYCLES = 40000000
) (
   input wire clock, // system clock
   input wire rstn, // async reset, active low
   input wire s_axi_arvalid, // read address valid
   input wire s_axi_arready, // read address ready
   input wire [31:0] s_axi_rdata, // read data
   input wire s_axi_rvalid, // read data valid
   input wire s_axi_rready, // read data ready
   input wire [1:0] s_axi_bresp, // write response
   input wire s_axi_bvalid, // write response valid
   input wire s_axi_bready, // write response ready
   input wire cooling_output, // cooling relay drive
   input wire aux_output, // auxiliary relay drive
   input wire defrost_active, // defrost running
   input wire show_message // display message phase
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   // ----------------------------------------
   // phase counters
   // ----------------------------------------
   int hi_cnt;
   int lo_cnt;
   logic hi_seen;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         hi_cnt <= 0;
         lo_cnt <= 0;
         hi_seen <= 1'b0;
      end else begin
         hi_cnt <= show_message ? hi_cnt + 1 : 0;
         lo_cnt <= (defrost_active && !show_message) ? lo_cnt + 1 : 0;
         // first value phase may be partial, so only judge after a message phase
         hi_seen <= defrost_active && (hi_seen || show_message);
      end
   end
   // ----------------------------------------
   // properties
   // ----------------------------------------
   chk_msg_len: assert property (
      $fell(show_message) && defrost_active |-> hi_cnt == TICK_CYCLES)
      else $error("message phase length wrong");
   chk_pv_len: assert property (
      $rose(show_message) && hi_seen |-> lo_cnt == 2 * TICK_CYCLES)
      else $error("value phase length wrong");
   chk_msg_in_defrost: assert property (
      show_message |-> defrost_active || $past(defrost_active))
      else $error("message shown outside defrost");
   chk_cool_held_off: assert property (defrost_active |-> !cooling_output)
      else $error("cooling driven during defrost");
   chk_start_cool: assert property ($rose(defrost_active) |-> !$past(cooling_output))
      else $error("defrost started while cooling driven");
   chk_aux_defrost: assert property (
      aux_output |-> defrost_active || $past(defrost_active))
      else $error("aux output outside defrost");
   chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response not held");
   chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   chk_r_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while answer pending");
endmodule // dfs_defrost_sequencer_chk

bind dfs_defrost_sequencer dfs_defrost_sequencer_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
   .clock(clock), .rstn(rstn), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .cooling_output(cooling_output), .aux_output(aux_output),
   .defrost_active(defrost_active), .show_message(show_message)
);

// File: dv/dfs_defrost_sequencer_tb.sv
`include "dfs_regs.vh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin miscompares++; \
   $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module dfs_defrost_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock, rstn, sensor_fault, control_demand, binary_input, pl;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [15:0] process_value;
   logic cooling_output, aux_output, defrost_active, show_message, manual_led;
   int miscompares, check_count, cyc, n, lc;
   logic [31:0] abort_ctrl [3] = '{32'h00000106, 32'h00000004, 32'h00000086};
   dfs_defrost_sequencer #(.TICK_CYCLES(8)) DUT (
      .clock(clock), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .process_value(process_value), .sensor_fault(sensor_fault),
      .control_demand(control_demand), .binary_input(binary_input),
      .cooling_output(cooling_output), .aux_output(aux_output),
      .defrost_active(defrost_active), .show_message(show_message), .manual_led(manual_led)
   );
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   // ----------------------------------------
   // bus tasks
   // ----------------------------------------
   // ready is sampled at the falling edge, where it is settled for the next rising edge
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      logic aw, w, b;
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(negedge clock);
         aw = s_axi_awvalid && s_axi_awready;
         w = s_axi_wvalid && s_axi_wready;
         b = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge clock);
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
      end while (!b);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a);
      logic ar, rv;
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(negedge clock);
         ar = s_axi_arvalid && s_axi_arready;
         rv = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge clock);
         if (ar) s_axi_arvalid <= 1'b0;
      end while (!rv);
      s_axi_rready <= 1'b0;
   endtask
   task automatic wact(input logic v, input int lim);
      n = 0;
      while (defrost_active !== v && n < lim) begin
         @(negedge clock);
         n++;
      end
      `CHK(defrost_active, v)
      @(posedge clock);
   endtask
   // counts cycles in which a defrost wrongly runs
   task automatic quiet(input int lim);
      n = 0;
      repeat (lim) begin
         @(negedge clock);
         if (defrost_active !== 1'b0) n++;
      end
      @(posedge clock);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         conclude();
      end
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      rstn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
      s_axi_wstrb = 4'hF;
      {sensor_fault, control_demand, binary_input} = 3'h0;
      process_value = 16'h0000;
      repeat (12) @(posedge clock);
      rstn <= 1'b1;
      rd(`DFS_INTERVAL_ADDR); `CHK(d, {16'h0000, `DFS_INTERVAL_RESET})
      rd(`DFS_MAX_TIME_ADDR); `CHK(d, {16'h0000, `DFS_MAX_TIME_RESET})
      rd(`DFS_FAULT_TIME_ADDR); `CHK(d, {16'h0000, `DFS_FAULT_TIME_RESET})
      rd(`DFS_CTRL_ADDR); `CHK(d, `DFS_CTRL_RESET)
      rd(12'h040); `CHK(r, `DFS_AXI_SLVERR)
      wr(12'h040, 32'h00000000); `CHK(r, `DFS_AXI_SLVERR)
      wr(`DFS_SETPOINT_ADDR, 32'h0000000A); `CHK(r, `DFS_AXI_OKAY)
      wr(`DFS_END_TEMP_ADDR, 32'h00000032);
      wr(`DFS_MAX_TIME_ADDR, 32'h00000007);
      wr(`DFS_FAULT_TIME_ADDR, 32'h00000002);
      wr(`DFS_CTRL_ADDR, 32'h00000002);
      quiet(40); `CHK(n, 0)
      control_demand <= 1'b1;
      wr(`DFS_CTRL_ADDR, 32'h00000026);
      quiet(40); `CHK(n, 0)
      rd(`DFS_STATUS_ADDR); `CHK(d[3], 1'b1)
      control_demand <= 1'b0;
      wact(1'b1, 16);
      @(negedge clock); `CHK(aux_output, 1'b1)
      `CHK(cooling_output, 1'b0)
      @(posedge clock);
      process_value <= 16'h0032;
      wact(1'b0, 8);
      rd(`DFS_CTRL_ADDR); `CHK(d[1:0], `DFS_MODE_OFF)
      wr(`DFS_CTRL_ADDR, 32'h00000006);
      quiet(40); `CHK(n, 0)
      process_value <= 16'h0000;
      wact(1'b1, 16);
      wact(1'b0, 80); `CHK(n inside {[48:64]}, 1'b1)
      wr(`DFS_CTRL_ADDR, 32'h0000000E);
      wact(1'b1, 16);
      process_value <= 16'h003C;
      wact(1'b0, 80); `CHK(n inside {[48:64]}, 1'b1)
      process_value <= 16'h0000;
      sensor_fault <= 1'b1;
      wr(`DFS_CTRL_ADDR, 32'h00000006);
      wact(1'b1, 16);
      wact(1'b0, 40); `CHK(n inside {[8:24]}, 1'b1)
      sensor_fault <= 1'b0;
      for (int i = 0; i < 3; i++) begin
         // hand mode runs once only: leave it first so that it rearms
         wr(`DFS_CTRL_ADDR, 32'h00000004);
         wr(`DFS_CTRL_ADDR, 32'h00000006);
         wact(1'b1, 16);
         wr(`DFS_CTRL_ADDR, abort_ctrl[i]);
         wact(1'b0, 4);
      end
      wr(`DFS_MANUAL_ADDR, 32'h000002BC);
      rd(`DFS_MANUAL_ADDR); `CHK(d, 32'h000003E8)
      @(negedge clock); `CHK(cooling_output, 1'b1)
      lc = 0;
      pl = manual_led;
      repeat (32) begin
         @(negedge clock);
         if (manual_led !== pl) lc++;
         pl = manual_led;
      end
      `CHK(lc, 4)
      wr(`DFS_CTRL_ADDR, 32'h000000C4);
      wr(`DFS_MANUAL_ADDR, 32'h0000012C);
      rd(`DFS_MANUAL_ADDR); `CHK(d, 32'h0000012C)
      @(negedge clock); `CHK(cooling_output, 1'b0)
      wr(`DFS_CTRL_ADDR, 32'h00000014);
      binary_input <= 1'b1;
      wact(1'b1, 16);
      process_value <= 16'h0032;
      wact(1'b0, 8);
      process_value <= 16'h0000;
      quiet(40); `CHK(n, 0)
      binary_input <= 1'b0;
      repeat (4) @(posedge clock);
      binary_input <= 1'b1;
      wact(1'b1, 16);
      process_value <= 16'h0032;
      wact(1'b0, 8);
      process_value <= 16'h0000;
      binary_input <= 1'b0;
      wr(`DFS_INTERVAL_ADDR, 32'h00000002);
      wr(`DFS_MAX_TIME_ADDR, 32'h00000001);
      wr(`DFS_CTRL_ADDR, 32'h00000015);
      wact(1'b1, 40);
      wact(1'b0, 24);
      wact(1'b1, 40);
      conclude();
   end
endmodule // dfs_defrost_sequencer_tb
